// ==== src/alop_alu.sv ====
// Purpose: Combinational result and flag computation for one operation.
// Assumes: x is the destination operand, y the source operand.
// Notes:   Flags not marked for update are left to the caller.
`default_nettype none

module alop_alu
	import alop_pkg::*;
(
	input  wire alop_op_t   op,    // Operation
	input  wire logic [7:0] x,     // Destination operand
	input  wire logic [7:0] y,     // Source operand
	input  wire logic [7:0] b_in,  // Auxiliary B register
	input  wire logic       cy_in, // Carry flag
	input  wire logic       ac_in, // Auxiliary carry flag
	output alop_alu_out_t   o      // Result and flags
);

	logic [8:0]  s9;
	logic [4:0]  n5;
	logic [15:0] prod;
	logic        cin;

	always_comb
	begin
		o = '0;
		o.res = x;
		o.b_res = b_in;
		o.cy = cy_in;
		o.ac = ac_in;
		s9 = 9'h000;
		n5 = 5'h00;
		prod = 16'h0000;
		cin = (op == OP_SUM_WITH_CARRY) ? cy_in : 1'b0;
		case (op)
			// RL2 full add flags
			OP_ADD, OP_SUM_WITH_CARRY:
			begin
				s9 = {1'b0, x} + {1'b0, y} + {8'h00, cin};
				n5 = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
				o.res = s9[7:0];
				o.cy = s9[8];
				o.ac = n5[4];
				o.ov = (x[7] == y[7]) && (s9[7] != x[7]);
				{o.upd_cy, o.upd_ac, o.upd_ov} = 3'b111;
			end
			// RL6 borrow flags
			OP_SUBTRACT_WITH_BORROW:
			begin
				s9 = {1'b0, x} - {1'b0, y} - {8'h00, cy_in};
				n5 = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cy_in};
				o.res = s9[7:0];
				o.cy = s9[8];
				o.ac = n5[4];
				o.ov = (x[7] != y[7]) && (s9[7] != x[7]);
				{o.upd_cy, o.upd_ac, o.upd_ov} = 3'b111;
			end
			OP_BITWISE_OR:  o.res = x | y;
			OP_BITWISE_AND: o.res = x & y;
			OP_BITWISE_XOR: o.res = x ^ y;
			OP_INC:         o.res = x + 8'h01;
			OP_DEC:         o.res = x - 8'h01;
			// RL13 right rotations
			OP_ROT_RIGHT:   o.res = {x[0], x[7:1]};
			OP_ROTATE_RIGHT_VIA_CARRY:
			begin
				o.res = {cy_in, x[7:1]};
				o.cy = x[0];
				o.upd_cy = 1'b1;
			end
			// RL12 left rotations
			OP_ROT_LEFT:    o.res = {x[6:0], x[7]};
			OP_ROTATE_LEFT_VIA_CARRY:
			begin
				o.res = {x[6:0], cy_in};
				o.cy = x[7];
				o.upd_cy = 1'b1;
			end
			// RL17 multiply and divide
			OP_MUL:
			begin
				prod = x * b_in;
				o.res = prod[7:0];
				o.b_res = prod[15:8];
				o.cy = 1'b0;
				o.ov = |prod[15:8];
				{o.upd_cy, o.upd_ov, o.upd_b} = 3'b111;
			end
			OP_DIV:
			begin
				o.cy = 1'b0;
				o.ov = (b_in == 8'h00);
				if (b_in != 8'h00)
				begin
					o.res = x / b_in;
					o.b_res = x % b_in;
				end
				{o.upd_cy, o.upd_ov, o.upd_b} = 3'b111;
			end
			OP_DEC_ADJUST:
			begin
				s9 = {1'b0, x};
				if ((x[3:0] > 4'h9) || ac_in)
				begin
					s9 = s9 + 9'h006;
				end
				if ((s9[7:4] > 4'h9) || s9[8] || cy_in)
				begin
					s9 = s9 + 9'h060;
				end
				o.res = s9[7:0];
				o.cy = cy_in | s9[8];
				o.upd_cy = 1'b1;
			end
			// RL18 carry left alone
			OP_CLR:  o.res = 8'h00;
			OP_CPL:  o.res = ~x;
			OP_SWAP: o.res = {x[3:0], x[7:4]};
			default: o.res = x;
		endcase
	end

endmodule : alop_alu

`default_nettype wire

// ==== src/alop_core.sv ====
// Purpose: Decode and execute the arithmetic and logical instruction groups.
// Assumes: Instruction bytes arrive whole from a fetch unit on mclk.
// Notes:   Each instruction cycle is CLK_PER_CYC clocks; done pulses at the end of the last one.
// Notes on behaviour
// RL1: Standard opcode encoding accepted; each decoded opcode does the standard operation.
// RL2: Carry, auxiliary carry, overflow and parity follow the standard core exactly.
// RL3: Timing is this core's own: fixed clocks per cycle, table cycle counts.
// RL4: Add decoded for bank register, direct, indirect and immediate sources.
// RL5: Add with carry for bank register, direct, indirect; short forms one cycle.
// RL6: Subtract with borrow for bank register, direct, indirect and immediate.
// RL7: AND into accumulator from bank register, direct and immediate; two-byte forms two cycles.
// RL8: AND into direct byte from accumulator (2 cycles) or immediate (3 cycles).
// RL9: OR into accumulator from bank registers; into direct byte from accumulator or immediate.
// RL10: XOR into accumulator from bank register, direct and immediate sources.
// RL11: XOR into direct byte from accumulator or immediate (three bytes, three cycles).
// RL12: Rotate left, plain and through carry, one byte one cycle.
// RL13: Rotate right, plain and through carry, one byte one cycle.
// RL14: Displacement bytes are signed two's complement values.
// RL15: Indirect address comes from bank register 0 or 1, by opcode bit 0.
// RL16: Inc/dec on accumulator, register, direct, indirect; pointer increment three cycles.
// RL17: Multiply and divide take five cycles; decimal adjust takes one.
// RL18: Clear, complement and swap are one cycle and keep carry.
`default_nettype none

module alop_core
	import alop_pkg::*;
(
	input  wire logic         mclk,                    // Core clock, 100 MHz
	input  wire logic         sys_rst,                 // Synchronous reset, active high
	input  wire logic         clk_en,                  // Freezes all state while low
	input  wire logic         instr_valid,             // Instruction offered
	input  wire alop_instr_t  instr,                   // Opcode and operand bytes
	output logic              instr_ready,             // Core idle, takes instr_valid
	output logic              instr_done,              // One-clock pulse at end
	output logic              instr_bad,               // Pulse with done, opcode not handled
	output logic        [7:0] acc_out,                 // Accumulator
	output logic        [7:0] b_out,                   // Auxiliary B register
	output logic        [7:0] psw_out,                 // Status word
	output logic       [15:0] sixteen_bit_pointer_out, // Data pointer
	output logic       [15:0] disp_ext                 // Sign-extended byte1 of last instruction
);

	alop_state_t   state_reg, state_next;
	logic [4:0]    cnt_reg, cnt_next;
	logic [4:0]    total_reg, total_next;
	alop_instr_t   ins_reg, ins_next;
	alop_op_t      op_reg, op_next;
	alop_form_t    form_reg, form_next;
	logic          dst_mem_reg, dst_mem_next;
	logic [7:0]    loc_reg, loc_next;
	logic [7:0]    acc_reg, acc_next;
	logic [7:0]    b_reg, b_next;
	logic [7:0]    psw_reg, psw_next;
	logic [15:0]   ptr16_reg, ptr16_next;
	logic          ready_reg, ready_next;
	logic          done_reg, done_next;
	logic          bad_reg, bad_next;
	logic [15:0]   disp_reg, disp_next;

	alop_op_t      dec_op;
	alop_form_t    dec_form;
	logic          dec_dst_mem;
	logic [3:0]    dec_cyc;
	logic [3:0]    hi;
	logic [3:0]    lo;
	logic          logic_grp;
	logic          accept;

	logic [7:0]    ram_raddr;
	logic [7:0]    ram_rdata;
	logic          ram_we;
	logic [7:0]    opnd;
	logic [7:0]    sfr_val;
	logic          sfr_hit;
	logic [7:0]    alu_x;
	logic [7:0]    alu_y;
	alop_alu_out_t alu;

	assign accept = (state_reg == ST_IDLE) && instr_valid && clk_en;
	assign hi = instr.opcode[7:4];
	assign lo = instr.opcode[3:0];
	assign logic_grp = (hi == 4'h4) || (hi == 4'h5) || (hi == 4'h6);

	// RL1 opcode decode
	always_comb
	begin
		dec_op = OP_NONE;
		dec_form = FM_ACC;
		dec_dst_mem = 1'b0;
		dec_cyc = CYC_ONE;
		case (instr.opcode)
			8'h03: dec_op = OP_ROT_RIGHT;
			8'h13: dec_op = OP_ROTATE_RIGHT_VIA_CARRY;
			8'h23: dec_op = OP_ROT_LEFT;
			8'h33: dec_op = OP_ROTATE_LEFT_VIA_CARRY;
			8'h04: dec_op = OP_INC;
			8'h14: dec_op = OP_DEC;
			8'hd4: dec_op = OP_DEC_ADJUST;
			8'he4: dec_op = OP_CLR;
			8'hf4: dec_op = OP_CPL;
			8'hc4: dec_op = OP_SWAP;
			// RL16 pointer increment
			8'ha3:
			begin
				dec_op = OP_POINTER_INC;
				dec_cyc = CYC_THREE;
			end
			// RL17 long operations
			8'ha4:
			begin
				dec_op = OP_MUL;
				dec_cyc = CYC_FIVE;
			end
			8'h84:
			begin
				dec_op = OP_DIV;
				dec_cyc = CYC_FIVE;
			end
			default:
			begin
				case (hi)
					4'h0: dec_op = OP_INC;
					4'h1: dec_op = OP_DEC;
					4'h2: dec_op = OP_ADD;
					// RL5 carry add group
					4'h3: dec_op = OP_SUM_WITH_CARRY;
					4'h4: dec_op = OP_BITWISE_OR;
					// RL7 and group
					4'h5: dec_op = OP_BITWISE_AND;
					// RL10 xor group
					4'h6: dec_op = OP_BITWISE_XOR;
					4'h9: dec_op = OP_SUBTRACT_WITH_BORROW;
					default: dec_op = OP_NONE;
				endcase
				// RL4 source forms
				if (lo[3])
				begin
					dec_form = FM_BANK_REGISTER;
				end
				else if (lo[3:1] == 3'b011)
				begin
					dec_form = FM_INDIRECT;
				end
				else if (lo == 4'h5)
				begin
					dec_form = FM_DIR;
					dec_cyc = CYC_TWO;
				end
				else if (lo == 4'h4)
				begin
					dec_form = FM_IMM;
					dec_cyc = CYC_TWO;
				end
				// RL8 direct destination, accumulator source
				else if ((lo == 4'h2) && logic_grp)
				begin
					dec_form = FM_DIR;
					dec_dst_mem = 1'b1;
					dec_cyc = CYC_TWO;
				end
				// RL11 direct destination, immediate source
				else if ((lo == 4'h3) && logic_grp)
				begin
					dec_form = FM_DIR;
					dec_dst_mem = 1'b1;
					dec_cyc = CYC_THREE;
				end
				else
				begin
					dec_op = OP_NONE;
				end
				// RL16 memory increment and decrement
				if ((hi == 4'h0) || (hi == 4'h1))
				begin
					dec_dst_mem = 1'b1;
				end
			end
		endcase
	end

	// Special register read for direct addresses in the upper half
	always_comb
	begin
		if (loc_reg == SFR_ACC)
			sfr_val = acc_reg;
		else if (loc_reg == SFR_B)
			sfr_val = b_reg;
		else if (loc_reg == SFR_PSW)
			sfr_val = psw_reg;
		else if (loc_reg == SFR_PTR_LO)
			sfr_val = ptr16_reg[7:0];
		else if (loc_reg == SFR_PTR_HI)
			sfr_val = ptr16_reg[15:8];
		else
			sfr_val = 8'h00;
	end

	assign sfr_hit = (form_reg == FM_DIR) && loc_reg[7];

	always_comb
	begin
		if (form_reg == FM_IMM)
			opnd = ins_reg.byte1;
		else if (sfr_hit)
			opnd = sfr_val;
		else
			opnd = ram_rdata;
	end

	// RL9 destination byte combined with accumulator or immediate
	assign alu_x = dst_mem_reg ? opnd : acc_reg;
	assign alu_y = !dst_mem_reg ? opnd : (ins_reg.opcode[0] ? ins_reg.byte2 : acc_reg);

	alop_alu u_alu (
		.op    (op_reg),
		.x     (alu_x),
		.y     (alu_y),
		.b_in  (b_reg),
		.cy_in (psw_reg[PSW_CY]),
		.ac_in (psw_reg[PSW_AC]),
		.o     (alu)
	);

	alop_ram u_ram (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.en      (clk_en),
		.we      (ram_we),
		.waddr   (loc_reg),
		.wdata   (alu.res),
		.raddr   (ram_raddr),
		.rdata   (ram_rdata)
	);

	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		total_next = total_reg;
		ins_next = ins_reg;
		op_next = op_reg;
		form_next = form_reg;
		dst_mem_next = dst_mem_reg;
		loc_next = loc_reg;
		acc_next = acc_reg;
		b_next = b_reg;
		psw_next = psw_reg;
		ptr16_next = ptr16_reg;
		disp_next = disp_reg;
		done_next = 1'b0;
		bad_next = 1'b0;
		ram_we = 1'b0;
		ram_raddr = loc_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (instr_valid)
				begin
					ins_next = instr;
					op_next = dec_op;
					form_next = dec_form;
					dst_mem_next = dec_dst_mem;
					// RL3 own cycle count
					total_next = 5'(dec_cyc * CLK_PER_CYC);
					cnt_next = CNT_START;
					// RL14 signed displacement
					disp_next = alop_rel_ext(instr.byte1);
					state_next = ST_PTR;
				end
			end
			ST_PTR:
			begin
				// RL15 pointer from bank register 0 or 1
				if (form_reg == FM_INDIRECT)
					loc_next = alop_bank_addr(psw_reg[PSW_RS1:PSW_RS0], {2'b00, ins_reg.opcode[0]});
				else if (form_reg == FM_BANK_REGISTER)
					loc_next = alop_bank_addr(psw_reg[PSW_RS1:PSW_RS0], ins_reg.opcode[2:0]);
				else
					loc_next = ins_reg.byte1;
				ram_raddr = loc_next;
				cnt_next = cnt_reg + 5'h01;
				state_next = ST_OPND;
			end
			ST_OPND:
			begin
				if (form_reg == FM_INDIRECT)
					loc_next = ram_rdata;
				ram_raddr = loc_next;
				cnt_next = cnt_reg + 5'h01;
				state_next = ST_EXEC;
			end
			ST_EXEC:
			begin
				// RL2 flag effects
				psw_next[PSW_CY] = alu.upd_cy ? alu.cy : psw_reg[PSW_CY];
				psw_next[PSW_AC] = alu.upd_ac ? alu.ac : psw_reg[PSW_AC];
				psw_next[PSW_OV] = alu.upd_ov ? alu.ov : psw_reg[PSW_OV];
				if (alu.upd_b)
					b_next = alu.b_res;
				if (op_reg == OP_POINTER_INC)
					ptr16_next = ptr16_reg + 16'h0001;
				else if (op_reg == OP_NONE)
					psw_next = psw_reg;
				else if (!dst_mem_reg)
					acc_next = alu.res;
				else if (!sfr_hit)
					ram_we = 1'b1;
				else if (loc_reg == SFR_ACC)
					acc_next = alu.res;
				else if (loc_reg == SFR_B)
					b_next = alu.res;
				else if (loc_reg == SFR_PSW)
					psw_next = alu.res;
				else if (loc_reg == SFR_PTR_LO)
					ptr16_next[7:0] = alu.res;
				else if (loc_reg == SFR_PTR_HI)
					ptr16_next[15:8] = alu.res;
				cnt_next = cnt_reg + 5'h01;
				state_next = ST_HOLD;
			end
			ST_HOLD:
			begin
				if (cnt_reg == total_reg)
				begin
					done_next = 1'b1;
					bad_next = (op_reg == OP_NONE);
					state_next = ST_IDLE;
				end
				else
					cnt_next = cnt_reg + 5'h01;
			end
			default: state_next = ST_IDLE;
		endcase
		// RL2 parity tracks the accumulator
		psw_next[PSW_P] = ^acc_next;
		ready_next = (state_next == ST_IDLE);
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 5'h00;
			total_reg <= 5'h00;
			ins_reg <= '0;
			op_reg <= OP_NONE;
			form_reg <= FM_ACC;
			dst_mem_reg <= 1'b0;
			loc_reg <= 8'h00;
			acc_reg <= ACC_RST;
			b_reg <= B_RST;
			psw_reg <= PSW_RST;
			ptr16_reg <= PTR16_RST;
			ready_reg <= 1'b1;
			done_reg <= 1'b0;
			bad_reg <= 1'b0;
			disp_reg <= 16'h0000;
		end
		else if (clk_en)
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			total_reg <= total_next;
			ins_reg <= ins_next;
			op_reg <= op_next;
			form_reg <= form_next;
			dst_mem_reg <= dst_mem_next;
			loc_reg <= loc_next;
			acc_reg <= acc_next;
			b_reg <= b_next;
			psw_reg <= psw_next;
			ptr16_reg <= ptr16_next;
			ready_reg <= ready_next;
			done_reg <= done_next;
			bad_reg <= bad_next;
			disp_reg <= disp_next;
		end
	end

	assign instr_ready = ready_reg;
	assign instr_done = done_reg;
	assign instr_bad = bad_reg;
	assign acc_out = acc_reg;
	assign b_out = b_reg;
	assign psw_out = psw_reg;
	assign sixteen_bit_pointer_out = ptr16_reg;
	assign disp_ext = disp_reg;

	property p_add_acc;
		@(posedge mclk) disable iff (sys_rst)
		(state_reg == ST_EXEC && clk_en && op_reg == OP_ADD)
		|=> acc_reg == 8'($past(acc_reg) + $past(opnd));
	endproperty
	a_add_acc: assert property (p_add_acc) else $error("add result wrong"); // RL4

	property p_carry_add;
		@(posedge mclk) disable iff (sys_rst)
		(state_reg == ST_EXEC && clk_en && op_reg == OP_SUM_WITH_CARRY)
		|=> psw_reg[PSW_CY] == ((9'($past(acc_reg)) + 9'($past(opnd))
			+ 9'($past(psw_reg[PSW_CY]))) > 9'h0ff);
	endproperty
	a_carry_add: assert property (p_carry_add) else $error("carry add flag wrong"); // RL5

	property p_sub_acc;
		@(posedge mclk) disable iff (sys_rst)
		(state_reg == ST_EXEC && clk_en && op_reg == OP_SUBTRACT_WITH_BORROW)
		|=> acc_reg == 8'($past(acc_reg) - $past(opnd) - 8'($past(psw_reg[PSW_CY])));
	endproperty
	a_sub_acc: assert property (p_sub_acc) else $error("subtract result wrong"); // RL6

	property p_parity;
		@(posedge mclk) disable iff (sys_rst)
		psw_reg[PSW_P] == ^acc_reg;
	endproperty
	a_parity: assert property (p_parity) else $error("parity flag wrong"); // RL2

	property p_rot_left;
		@(posedge mclk) disable iff (sys_rst)
		(state_reg == ST_EXEC && clk_en && op_reg == OP_ROT_LEFT)
		|=> acc_reg == 8'(($past(acc_reg) << 1) | ($past(acc_reg) >> 7))
			&& $stable(psw_reg[PSW_CY]);
	endproperty
	a_rot_left: assert property (p_rot_left) else $error("rotate left wrong"); // RL12

	property p_rot_right_cy;
		@(posedge mclk) disable iff (sys_rst)
		(state_reg == ST_EXEC && clk_en && op_reg == OP_ROTATE_RIGHT_VIA_CARRY)
		|=> psw_reg[PSW_CY] == $past(acc_reg[0]);
	endproperty
	a_rot_right_cy: assert property (p_rot_right_cy) else $error("rotate carry wrong"); // RL13

	property p_keep_carry;
		@(posedge mclk) disable iff (sys_rst)
		(state_reg == ST_EXEC && clk_en && (op_reg == OP_CLR || op_reg == OP_CPL
			|| op_reg == OP_SWAP)) |=> $stable(psw_reg[PSW_CY]);
	endproperty
	a_keep_carry: assert property (p_keep_carry) else $error("carry changed"); // RL18

	property p_mul;
		@(posedge mclk) disable iff (sys_rst)
		(state_reg == ST_EXEC && clk_en && op_reg == OP_MUL)
		|=> {b_reg, acc_reg} == 16'(16'($past(acc_reg)) * 16'($past(b_reg)));
	endproperty
	a_mul: assert property (p_mul) else $error("multiply wrong"); // RL17

	property p_one_cycle;
		@(posedge mclk) disable iff (sys_rst)
		(accept && dec_cyc == CYC_ONE) ##1 clk_en[*4] |=> instr_done && instr_ready;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("one-cycle timing wrong"); // RL3

	property p_indirect;
		@(posedge mclk) disable iff (sys_rst)
		(state_reg == ST_PTR && form_reg == FM_INDIRECT)
		|-> loc_next == ({3'b000, psw_reg[PSW_RS1:PSW_RS0], 3'b000}
			+ {7'h00, ins_reg.opcode[0]});
	endproperty
	a_indirect: assert property (p_indirect) else $error("indirect pointer wrong"); // RL15

	property p_disp;
		@(posedge mclk) disable iff (sys_rst)
		accept |=> $signed(disp_ext) == $signed($past(instr.byte1));
	endproperty
	a_disp: assert property (p_disp) else $error("displacement wrong"); // RL14

endmodule : alop_core

`default_nettype wire

// ==== src/alop_pkg.sv ====
// Purpose: Shared constants, types and helpers of the arithmetic/logic core.
// Assumes: One clock (mclk), synchronous active-high reset.
// Notes:   Timing is counted in instruction cycles of CLK_PER_CYC clocks.
`default_nettype none

package alop_pkg;

	// Clocks per instruction cycle; stages need three, the fourth closes the cycle
	localparam int         CLK_PER_CYC = 4;
	localparam logic [3:0] CYC_ONE     = 4'h1;
	localparam logic [3:0] CYC_TWO     = 4'h2;
	localparam logic [3:0] CYC_THREE   = 4'h3;
	localparam logic [3:0] CYC_FIVE    = 4'h5;
	localparam logic [4:0] CNT_START   = 5'h01;

	// Direct addresses with bit 7 set reach special registers, not RAM
	localparam logic [7:0] SFR_ACC     = 8'he0;
	localparam logic [7:0] SFR_B       = 8'hf0;
	localparam logic [7:0] SFR_PSW     = 8'hd0;
	localparam logic [7:0] SFR_PTR_LO  = 8'h82;
	localparam logic [7:0] SFR_PTR_HI  = 8'h83;

	localparam logic [7:0]  ACC_RST    = 8'h00;
	localparam logic [7:0]  B_RST      = 8'h00;
	localparam logic [7:0]  PSW_RST    = 8'h00;
	localparam logic [15:0] PTR16_RST  = 16'h0000;

	// Status word bit positions
	localparam int PSW_CY  = 7;
	localparam int PSW_AC  = 6;
	localparam int PSW_RS1 = 4;
	localparam int PSW_RS0 = 3;
	localparam int PSW_OV  = 2;
	localparam int PSW_P   = 0;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_PTR  = 5'b00010,
		ST_OPND = 5'b00100,
		ST_EXEC = 5'b01000,
		ST_HOLD = 5'b10000
	} alop_state_t;

	typedef enum logic [4:0] {
		OP_NONE, OP_ADD, OP_SUM_WITH_CARRY, OP_SUBTRACT_WITH_BORROW,
		OP_BITWISE_OR, OP_BITWISE_AND, OP_BITWISE_XOR, OP_INC, OP_DEC,
		OP_ROT_RIGHT, OP_ROTATE_RIGHT_VIA_CARRY, OP_ROT_LEFT, OP_ROTATE_LEFT_VIA_CARRY,
		OP_MUL, OP_DIV, OP_DEC_ADJUST, OP_CLR, OP_CPL, OP_SWAP, OP_POINTER_INC
	} alop_op_t;

	typedef enum logic [2:0] {
		FM_ACC, FM_IMM, FM_DIR, FM_INDIRECT, FM_BANK_REGISTER
	} alop_form_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] byte1;
		logic [7:0] byte2;
	} alop_instr_t;

	typedef struct packed {
		logic [7:0] res;
		logic [7:0] b_res;
		logic       cy;
		logic       ac;
		logic       ov;
		logic       upd_cy;
		logic       upd_ac;
		logic       upd_ov;
		logic       upd_b;
	} alop_alu_out_t;

	// RAM address of a register in the selected bank
	function automatic logic [7:0] alop_bank_addr(input logic [1:0] bank, input logic [2:0] r);
		return {3'b000, bank, r};
	endfunction : alop_bank_addr

	// Displacement byte read as signed two's complement
	function automatic logic [15:0] alop_rel_ext(input logic [7:0] d);
		return {{8{d[7]}}, d};
	endfunction : alop_rel_ext

endpackage : alop_pkg

`default_nettype wire

// ==== src/alop_ram.sv ====
// Purpose: 256-byte internal data memory, one write and one read port.
// Assumes: Read data registered, one clock behind the address.
// Notes:   Enable freezes both ports.
`default_nettype none

module alop_ram
	import alop_pkg::*;
(
	input  wire logic       mclk,    // Core clock
	input  wire logic       sys_rst, // Synchronous reset
	input  wire logic       en,      // Clock enable
	input  wire logic       we,      // Write strobe
	input  wire logic [7:0] waddr,   // Write address
	input  wire logic [7:0] wdata,   // Write data
	input  wire logic [7:0] raddr,   // Read address
	output logic      [7:0] rdata    // Registered read data
);

	logic [7:0] mem [256];

	always_ff @(posedge mclk)
	begin
		if (en && we)
		begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rdata <= 8'h00;
		end
		else if (en)
		begin
			rdata <= mem[raddr];
		end
	end

endmodule : alop_ram

`default_nettype wire

// ==== verif/alop_tb.sv ====
// Purpose: Self-checking bench for the arithmetic/logic core.
// Assumes: Clock enable held high except in t_freeze; RAM bytes written before use.
// Notes:   Drives at falling edges; results checked after done.
`default_nettype none

module testbench
	import alop_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk;
	logic        sys_rst;
	logic        clk_en;
	logic        instr_valid;
	alop_instr_t instr;
	logic        instr_ready;
	logic        instr_done;
	logic        instr_bad;
	logic [7:0]  acc_out;
	logic [7:0]  b_out;
	logic [7:0]  psw_out;
	logic [15:0] ptr_out;
	logic [15:0] disp_ext;
	int          error_cnt;
	int          num_checks;
	int          cyc_cnt;

	alop_core dut (
		.mclk                    (mclk),
		.sys_rst                 (sys_rst),
		.clk_en                  (clk_en),
		.instr_valid             (instr_valid),
		.instr                   (instr),
		.instr_ready             (instr_ready),
		.instr_done              (instr_done),
		.instr_bad               (instr_bad),
		.acc_out                 (acc_out),
		.b_out                   (b_out),
		.psw_out                 (psw_out),
		.sixteen_bit_pointer_out (ptr_out),
		.disp_ext                (disp_ext)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run;
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	// Offer one instruction at a falling edge; returns at the falling edge where done shows
	task automatic run(input logic [7:0] op, b1, b2, input int cyc, input logic bad);
		int n;
		n = 0;
		instr_valid = 1'b1;
		instr = '{opcode: op, byte1: b1, byte2: b2};
		@(posedge mclk);
		@(negedge mclk);
		instr_valid = 1'b0;
		chk(16'(instr_ready), 16'h0000);
		while (instr_done !== 1'b1 && n < 40)
		begin
			@(negedge mclk);
			n++;
		end
		chk(16'(n), 16'(cyc * CLK_PER_CYC));
		chk(16'(instr_bad), 16'(bad));
	endtask : run

	task automatic st(input logic [7:0] a, input logic [7:0] p);
		chk(16'(acc_out), 16'(a));
		chk(16'(psw_out), 16'(p));
	endtask : st

	task automatic ld(input logic [7:0] adr, input logic [7:0] v);
		run(8'h53, adr, 8'h00, 3, 1'b0);
		run(8'h43, adr, v, 3, 1'b0);
	endtask : ld

	task automatic t_reset;
		chk({acc_out, b_out}, 16'h0000);
		chk(16'(psw_out), 16'h0000);
		chk(ptr_out, 16'h0000);
		chk(16'(instr_ready), 16'h0001);
	endtask : t_reset

	task automatic t_arith;
		run(8'he4, 8'h00, 8'h00, 1, 1'b0);
		run(8'h43, 8'he0, 8'h7f, 3, 1'b0);
		st(8'h7f, 8'h01);
		ld(8'h03, 8'h90);
		ld(8'h01, 8'h40);
		ld(8'h40, 8'h05);
		run(8'h24, 8'h01, 8'h00, 2, 1'b0);
		st(8'h80, 8'h45);
		run(8'h2b, 8'h00, 8'h00, 1, 1'b0);
		st(8'h10, 8'h85);
		run(8'h37, 8'h00, 8'h00, 1, 1'b0);
		st(8'h16, 8'h01);
		run(8'h94, 8'h97, 8'h00, 2, 1'b0);
		st(8'h7f, 8'hc1);
		chk(disp_ext, 16'hff97);
	endtask : t_arith

	task automatic t_logic;
		run(8'h64, 8'h0f, 8'h00, 2, 1'b0);
		st(8'h70, 8'hc1);
		run(8'h13, 8'h00, 8'h00, 1, 1'b0);
		st(8'hb8, 8'h40);
		run(8'h23, 8'h00, 8'h00, 1, 1'b0);
		st(8'h71, 8'h40);
		run(8'h03, 8'h00, 8'h00, 1, 1'b0);
		st(8'hb8, 8'h40);
		run(8'h33, 8'h00, 8'h00, 1, 1'b0);
		st(8'h70, 8'hc1);
		run(8'hc4, 8'h00, 8'h00, 1, 1'b0);
		st(8'h07, 8'hc1);
		run(8'hf4, 8'h00, 8'h00, 1, 1'b0);
		st(8'hf8, 8'hc1);
	endtask : t_logic

	task automatic t_muldiv;
		run(8'h43, 8'hf0, 8'h10, 3, 1'b0);
		run(8'ha4, 8'h00, 8'h00, 5, 1'b0);
		st(8'h80, 8'h45);
		chk(16'(b_out), 16'h000f);
		run(8'h84, 8'h00, 8'h00, 5, 1'b0);
		st(8'h08, 8'h41);
		chk(16'(b_out), 16'h0008);
		run(8'he4, 8'h00, 8'h00, 1, 1'b0);
		st(8'h00, 8'h40);
		run(8'ha3, 8'h00, 8'h00, 3, 1'b0);
		chk(ptr_out, 16'h0001);
	endtask : t_muldiv

	task automatic t_bad;
		// Unhandled opcode in a direct-address slot still runs two cycles
		run(8'ha5, 8'h12, 8'h00, 2, 1'b1);
		st(8'h00, 8'h40);
	endtask : t_bad

	task automatic t_mem;
		run(8'h63, 8'h03, 8'h0f, 3, 1'b0);
		run(8'h0b, 8'h00, 8'h00, 1, 1'b0);
		run(8'h17, 8'h00, 8'h00, 1, 1'b0);
		run(8'h2b, 8'h00, 8'h00, 1, 1'b0);
		st(8'ha0, 8'h00);
		run(8'h54, 8'h2f, 8'h00, 2, 1'b0);
		st(8'h20, 8'h01);
		run(8'h27, 8'h00, 8'h00, 1, 1'b0);
		st(8'h24, 8'h00);
	endtask : t_mem

	// Clock enable low stretches the instruction and holds every register
	task automatic t_freeze;
		int n;
		n = 0;
		instr_valid = 1'b1;
		instr = '{opcode: 8'h04, byte1: 8'h00, byte2: 8'h00};
		@(negedge mclk);
		instr_valid = 1'b0;
		clk_en = 1'b0;
		repeat (6) @(negedge mclk);
		chk(16'(acc_out), 16'h0024);
		clk_en = 1'b1;
		while (instr_done !== 1'b1 && n < 40)
		begin
			@(negedge mclk);
			n++;
		end
		chk(16'(n), 16'h0004);
		st(8'h25, 8'h01);
	endtask : t_freeze

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Hang guard
	always @(posedge mclk)
	begin
		cyc_cnt++;
		if (cyc_cnt >= 5000)
		begin
			error_cnt++;
			complete_run();
		end
	end

	initial
	begin
		error_cnt = 0;
		num_checks = 0;
		cyc_cnt = 0;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		instr_valid = 1'b0;
		instr = '0;
		repeat (4) @(negedge mclk);
		sys_rst = 1'b0;
		t_reset();
		t_arith();
		t_logic();
		t_muldiv();
		t_bad();
		t_mem();
		t_freeze();
		complete_run();
	end

endmodule : testbench

`default_nettype wire
